// ---- verilog/global_ctl_pkg.sv ----
// constants and register map of the counter global control block
//==================================================================
// Functional notes
// - read-only id word: bits 27..24 revision, bits 31..28 zero.
// - exchange bit 21 swaps dedicated pins of locations 0-3 and 4-7.
// - pairs 0/4,1/5,2/6,3/7 trade pins; register addressing unchanged.
// - exchange also covers quadrature inputs and output pins.
// - writing one to bit 31,23,15 or 7 clears that channel toggle.
// - toggle steers acknowledge to alternate halves of a 16-bit word.
// - lane-toggle clear bit is a strobe that clears itself.
// - four 5-bit selects pick the source of each request pin.
// - select values 0..3 route counter 0..3 request to the pin.
// - select 31 drives nothing, pin floats; this is the reset value.
// - enable bit 6 gates terminal count onto the counter interrupt.
// - pair reset bit 2 resets even counter, bit 3 the odd one.
// - reset strobe clears itself and leaves the counter disarmed.
// - counter reset clears the missed-load flag.
// - counter reset clears the sticky stale-data flag.
//==================================================================
package global_ctl_pkg;

   //==================================================================
   // register offsets
   localparam logic [11:0] OFF_PAIR_RESET = 12'h190;
   localparam logic [11:0] OFF_IRQ_ENABLE = 12'h192;
   localparam logic [11:0] OFF_SILICON_ID = 12'h700;
   localparam logic [11:0] OFF_CLOCK_PIN = 12'h73c;
   localparam logic [11:0] OFF_DMA_ROUTE = 12'h76c;
   localparam logic [11:0] OFF_EVT_STATUS = 12'h7a0;
   localparam logic [11:0] OFF_EVT_MASK = 12'h7a4;
   localparam logic [11:0] OFF_STATE = 12'h7a8;

   //==================================================================
   // field positions
   localparam int ID_REV_LSB = 24;
   localparam int SWAP_BIT = 21;
   localparam int DMA_CH_STRIDE = 8;
   localparam int DMA_CLEAR_BIT = 7;
   localparam int TC_ENABLE_BIT = 6;
   localparam int EVEN_RESET_BIT = 2;
   localparam int ODD_RESET_BIT = 3;

   // event status bits
   localparam int EV_TC = 0;
   localparam int EV_MISSED = 1;
   localparam int EV_STALE = 2;
   localparam int EV_ACK_DONE = 3;
   localparam int EV_W = 4;

   //==================================================================
   // widths, codes and reset values
   localparam int SEL_W = 5;
   localparam int DMA_CH = 4;
   localparam int LOCS = 8;
   localparam logic [4:0] SEL_NONE = 5'h1f;
   localparam logic [4:0] SEL_LAST_CTR = 5'h03;
   localparam logic SWAP_RESET = 1'b0;
   localparam logic IRQ_EN_RESET = 1'b0;
   localparam logic [3:0] MASK_RESET = 4'h0;

endpackage

// ---- verilog/pin_sync.sv ----
// three-stage pin synchroniser that accepts a level once stages agree
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 1
)(
   input wire logic clock, // 200 MHz
   input wire logic resetn, // async, active low
   input wire logic [W-1:0] d, // raw pin level
   output logic [W-1:0] q // accepted level
);

   logic [W-1:0] s1_q, s2_q, s3_q, q_q;
   logic [W-1:0] q_d;
   logic [W-1:0] agree;

   // stage one feeds stage two only, to keep metastability contained
   always_comb
   begin
      agree = ~(s2_q ^ s3_q);
      q_d = (agree & s3_q) | (~agree & q_q);
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         q_q <= '0;
      end
      else
      begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
         q_q <= q_d;
      end
   end

   assign q = q_q;

endmodule

// ---- verilog/counter_global_control.sv ----
// global and joint control registers of the multi-counter timing block
`timescale 1ns/1ps
module counter_global_control #(
   parameter logic [3:0] SILICON_REV = 4'h1 // arbitrary value
)(
   input wire logic clock, // 200 MHz
   input wire logic resetn, // async, active low
   input wire logic [11:0] addr, // register offset
   input wire logic [31:0] wdata, // write data
   input wire logic wr_en, // write strobe
   input wire logic rd_en, // read strobe
   output logic [31:0] rdata, // read data, cycle after rd_en
   input wire logic [7:0] pin_src, // source pins per location
   input wire logic [7:0] pin_gate, // gate pins
   input wire logic [7:0] pin_updown, // direction pins
   input wire logic [7:0] pin_aux, // quadrature index pins
   output logic [7:0] ctr_src, // source to counters
   output logic [7:0] ctr_gate, // gate to counters
   output logic [7:0] ctr_updown, // direction to counters
   output logic [7:0] ctr_aux, // quadrature index to counters
   input wire logic [7:0] ctr_out, // counter outputs
   output logic [7:0] pin_out, // output pins
   input wire logic [3:0] ctr_dma_req, // counter 0..3 requests
   output logic [3:0] dma_request_pin, // request pin level
   output logic [3:0] dma_request_oe, // request pin driven
   input wire logic [3:0] dma_acknowledge_pin, // acknowledge pins
   output logic [3:0] ack_low_lane, // ack on low half
   output logic [3:0] ack_high_lane, // ack on high half
   input wire logic terminal_count, // even counter terminal count
   output logic counter_irq, // gated terminal count
   input wire logic [1:0] arm_event, // counter armed {odd,even}
   input wire logic [1:0] missed_load_event, // no load between gates
   input wire logic [1:0] stale_event, // stale data seen
   output logic even_counter_reset_strobe, // one-cycle reset
   output logic odd_counter_reset_strobe, // one-cycle reset
   output logic [1:0] counter_armed, // armed state
   output logic [1:0] missed_load_flag, // missed-load flags
   output logic [1:0] sticky_stale_flag, // sticky stale flags
   output logic irq // unmasked event pending
);

   //==================================================================
   // pin synchronisers
   logic [35:0] sync_v;
   logic [7:0] src_v, gate_v, updown_v, aux_v;
   logic [3:0] ack_v;

   pin_sync #(.W(36)) u_sync (
      .clock(clock),
      .resetn(resetn),
      .d({dma_acknowledge_pin, pin_aux, pin_updown, pin_gate, pin_src}),
      .q(sync_v)
   );

   assign src_v = sync_v[7:0];
   assign gate_v = sync_v[15:8];
   assign updown_v = sync_v[23:16];
   assign aux_v = sync_v[31:24];
   assign ack_v = sync_v[35:32];

   //==================================================================
   // write decode
   logic wr_pair, wr_irq, wr_clk, wr_dma, wr_stat, wr_mask;

   always_comb
   begin
      wr_pair = wr_en && addr == global_ctl_pkg::OFF_PAIR_RESET;
      wr_irq = wr_en && addr == global_ctl_pkg::OFF_IRQ_ENABLE;
      wr_clk = wr_en && addr == global_ctl_pkg::OFF_CLOCK_PIN;
      wr_dma = wr_en && addr == global_ctl_pkg::OFF_DMA_ROUTE;
      wr_stat = wr_en && addr == global_ctl_pkg::OFF_EVT_STATUS;
      wr_mask = wr_en && addr == global_ctl_pkg::OFF_EVT_MASK;
   end

   //==================================================================
   // configuration registers
   logic swap_q, swap_d;
   logic irq_en_q, irq_en_d;
   logic [3:0][4:0] sel_q, sel_d;
   logic [3:0] mask_q, mask_d;

   always_comb
   begin
      swap_d = swap_q;
      irq_en_d = irq_en_q;
      sel_d = sel_q;
      mask_d = mask_q;
      if (wr_clk)
         swap_d = wdata[global_ctl_pkg::SWAP_BIT];
      if (wr_irq)
         irq_en_d = wdata[global_ctl_pkg::TC_ENABLE_BIT];
      if (wr_mask)
         mask_d = wdata[3:0];
      if (wr_dma)
         for (int c = 0; c < global_ctl_pkg::DMA_CH; c++)
            sel_d[c] = wdata[c*global_ctl_pkg::DMA_CH_STRIDE +:
               global_ctl_pkg::SEL_W];
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         swap_q <= global_ctl_pkg::SWAP_RESET;
         irq_en_q <= global_ctl_pkg::IRQ_EN_RESET;
         sel_q <= {4{global_ctl_pkg::SEL_NONE}};
         mask_q <= global_ctl_pkg::MASK_RESET;
      end
      else
      begin
         swap_q <= swap_d;
         irq_en_q <= irq_en_d;
         sel_q <= sel_d;
         mask_q <= mask_d;
      end
   end

   //==================================================================
   // pin exchange between location groups 0-3 and 4-7
   function automatic logic [7:0] xchg(input logic [7:0] v, input logic s);
      xchg = s ? {v[3:0], v[7:4]} : v;
   endfunction

   logic [7:0] csrc_d, cgate_d, cupd_d, caux_d, pout_d;

   // only pins move; the register side never sees the exchange
   always_comb
   begin
      csrc_d = xchg(src_v, swap_q);
      cgate_d = xchg(gate_v, swap_q);
      cupd_d = xchg(updown_v, swap_q);
      caux_d = xchg(aux_v, swap_q);
      pout_d = xchg(ctr_out, swap_q);
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         ctr_src <= '0;
         ctr_gate <= '0;
         ctr_updown <= '0;
         ctr_aux <= '0;
         pin_out <= '0;
      end
      else
      begin
         ctr_src <= csrc_d;
         ctr_gate <= cgate_d;
         ctr_updown <= cupd_d;
         ctr_aux <= caux_d;
         pin_out <= pout_d;
      end
   end

   //==================================================================
   // request routing and acknowledge lane toggles
   logic [3:0] req_d, oe_d, tog_q, tog_d, ack_prev_q, lo_d, hi_d;
   logic ack_done;

   always_comb
   begin
      ack_done = 1'b0;
      for (int c = 0; c < global_ctl_pkg::DMA_CH; c++)
      begin
         if (sel_q[c] <= global_ctl_pkg::SEL_LAST_CTR)
         begin
            req_d[c] = ctr_dma_req[sel_q[c][1:0]];
            oe_d[c] = 1'b1;
         end
         else if (sel_q[c] == global_ctl_pkg::SEL_NONE)
         begin
            req_d[c] = 1'b0;
            oe_d[c] = 1'b0;
         end
         else
         begin
            req_d[c] = 1'b0;
            oe_d[c] = 1'b1;
         end
         // flip at the end of each access so the lane holds during it
         tog_d[c] = tog_q[c] ^ (ack_prev_q[c] & ~ack_v[c]);
         ack_done = ack_done | (ack_prev_q[c] & ~ack_v[c]);
         if (wr_dma && wdata[c*global_ctl_pkg::DMA_CH_STRIDE +
               global_ctl_pkg::DMA_CLEAR_BIT])
            tog_d[c] = 1'b0;
         lo_d[c] = ack_v[c] & ~tog_q[c];
         hi_d[c] = ack_v[c] & tog_q[c];
      end
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         dma_request_pin <= '0;
         dma_request_oe <= '0;
         tog_q <= '0;
         ack_prev_q <= '0;
         ack_low_lane <= '0;
         ack_high_lane <= '0;
      end
      else
      begin
         dma_request_pin <= req_d;
         dma_request_oe <= oe_d;
         tog_q <= tog_d;
         ack_prev_q <= ack_v;
         ack_low_lane <= lo_d;
         ack_high_lane <= hi_d;
      end
   end

   //==================================================================
   // pair reset strobes and counter flags
   logic ev_rst_d, od_rst_d;
   logic [1:0] rst_now, armed_d, missed_d, stale_d;

   always_comb
   begin
      // strobes only register the write decode, so they fall by themselves
      ev_rst_d = wr_pair && wdata[global_ctl_pkg::EVEN_RESET_BIT];
      od_rst_d = wr_pair && wdata[global_ctl_pkg::ODD_RESET_BIT];
      rst_now = {odd_counter_reset_strobe, even_counter_reset_strobe};
      // reset wins over arming: the counter is left disarmed
      armed_d = (counter_armed | arm_event) & ~rst_now;
      // a new event in the reset cycle is kept
      missed_d = (missed_load_flag & ~rst_now) | missed_load_event;
      stale_d = (sticky_stale_flag & ~rst_now) | stale_event;
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         even_counter_reset_strobe <= 1'b0;
         odd_counter_reset_strobe <= 1'b0;
         counter_armed <= '0;
         missed_load_flag <= '0;
         sticky_stale_flag <= '0;
      end
      else
      begin
         even_counter_reset_strobe <= ev_rst_d;
         odd_counter_reset_strobe <= od_rst_d;
         counter_armed <= armed_d;
         missed_load_flag <= missed_d;
         sticky_stale_flag <= stale_d;
      end
   end

   //==================================================================
   // events, interrupts and read data
   logic [3:0] status_q, status_d, ev_set;
   logic cirq_d, irq_d;
   logic [31:0] rdata_d;

   always_comb
   begin
      ev_set = '0;
      ev_set[global_ctl_pkg::EV_TC] = terminal_count;
      ev_set[global_ctl_pkg::EV_MISSED] = |missed_load_event;
      ev_set[global_ctl_pkg::EV_STALE] = |stale_event;
      ev_set[global_ctl_pkg::EV_ACK_DONE] = ack_done;
      status_d = status_q;
      if (wr_stat)
         status_d = status_q & ~wdata[3:0];
      status_d = status_d | ev_set;
      cirq_d = terminal_count & irq_en_q;
      irq_d = |(status_q & mask_q);
      rdata_d = '0;
      if (rd_en)
         case (addr)
            global_ctl_pkg::OFF_SILICON_ID:
               rdata_d[global_ctl_pkg::ID_REV_LSB +: 4] = SILICON_REV;
            global_ctl_pkg::OFF_EVT_STATUS: rdata_d[3:0] = status_q;
            global_ctl_pkg::OFF_EVT_MASK: rdata_d[3:0] = mask_q;
            global_ctl_pkg::OFF_STATE:
               rdata_d[13:0] = {tog_q, swap_q, irq_en_q, sticky_stale_flag,
                  missed_load_flag, counter_armed, 2'b00};
            default: rdata_d = '0;
         endcase
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         status_q <= '0;
         counter_irq <= 1'b0;
         irq <= 1'b0;
         rdata <= '0;
      end
      else
      begin
         status_q <= status_d;
         counter_irq <= cirq_d;
         irq <= irq_d;
         rdata <= rdata_d;
      end
   end

   //==================================================================
   // checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);

   a_id_readback: assert property (
      rd_en && addr == global_ctl_pkg::OFF_SILICON_ID |=>
      rdata == {4'h0, SILICON_REV, 24'h000000})
      else $error("id word wrong");
   a_swap_src_pins: assert property (
      swap_q && $stable(swap_q) |=>
      ctr_src == {$past(src_v[3:0]), $past(src_v[7:4])})
      else $error("source pins not exchanged");
   a_plain_out_pins: assert property (
      !swap_q |=> pin_out == $past(ctr_out))
      else $error("output pins moved without exchange");
   a_toggle_clear: assert property (
      wr_dma && wdata[global_ctl_pkg::DMA_CLEAR_BIT] |=>
      !tog_q[0] ##1 tog_q[0] == $past(ack_prev_q[0] & ~ack_v[0]))
      else $error("toggle not cleared");
   a_lane_alternate: assert property (
      ack_prev_q[1] && !ack_v[1] && !wr_dma |=>
      tog_q[1] != $past(tog_q[1]))
      else $error("lane did not alternate");
   a_drq_route: assert property (
      sel_q[2] <= global_ctl_pkg::SEL_LAST_CTR |=>
      dma_request_oe[2] &&
      dma_request_pin[2] == $past(ctr_dma_req[sel_q[2][1:0]]))
      else $error("request routed wrong");
   a_drq_float: assert property (
      sel_q[3] == global_ctl_pkg::SEL_NONE |=> !dma_request_oe[3])
      else $error("request pin driven at select 31");
   a_tc_gate: assert property (
      terminal_count |=> counter_irq == $past(irq_en_q))
      else $error("terminal count gating wrong");
   a_reset_strobe: assert property (
      wr_pair && wdata[global_ctl_pkg::ODD_RESET_BIT] |=>
      odd_counter_reset_strobe ##1 !counter_armed[1])
      else $error("odd reset missing or counter armed");
   a_missed_clear: assert property (
      even_counter_reset_strobe && !missed_load_event[0] |=>
      !missed_load_flag[0])
      else $error("missed-load flag survived reset");
   a_stale_clear: assert property (
      odd_counter_reset_strobe && !stale_event[1] |=>
      !sticky_stale_flag[1])
      else $error("stale flag survived reset");
   a_irq_level: assert property (
      |(status_q & mask_q) |=> irq)
      else $error("interrupt not raised");

   c_swap_used: cover property (swap_q && $changed(src_v));
   c_routed_req: cover property (dma_request_oe[0] && dma_request_pin[0]);
   c_pair_reset: cover property (even_counter_reset_strobe);
   c_irq_seen: cover property ($rose(irq));

endmodule

// ---- verification/dma_host_model.sv ----
// dma controller model that answers request pins with acknowledge pulses
`timescale 1ns/1ps
module dma_host_model (
   input wire logic clock, // 200 MHz
   input wire logic resetn, // async, active low
   input wire logic [3:0] req, // request pin level
   input wire logic [3:0] req_oe, // request pin driven
   output logic [3:0] ack // acknowledge pins
);
   //==================================================================
   // access sequencer
   // an access once started always runs out, even if the request drops
   logic [3:0] cnt_q [4];
   always_ff @(posedge clock or negedge resetn)
   begin
      for (int ch = 0; ch < 4; ch++)
      begin
         if (!resetn)
            cnt_q[ch] <= 4'h0;
         else if (cnt_q[ch] != 4'h0 || (req[ch] && req_oe[ch]))
            cnt_q[ch] <= cnt_q[ch] + 4'h1;
      end
   end
   // six cycles of acknowledge, then a gap long enough for the sync
   always_comb
   begin
      for (int ch = 0; ch < 4; ch++)
         ack[ch] = cnt_q[ch] >= 4'h1 && cnt_q[ch] <= 4'h6;
   end
endmodule

// ---- verification/tb_top.sv ----
// self-checking bench of the counter global control registers
`timescale 1ns/1ps
module tb_top;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic [11:0] addr = 12'h0;
   logic [31:0] wdata = 32'h0;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [31:0] rdata;
   logic [7:0] pin_src = 8'h0, pin_gate = 8'h0, pin_updown = 8'h0;
   logic [7:0] pin_aux = 8'h0, ctr_out = 8'h0;
   logic [7:0] ctr_src, ctr_gate, ctr_updown, ctr_aux, pin_out;
   logic [3:0] ctr_dma_req = 4'h0;
   logic [3:0] dma_request_pin, dma_request_oe, ack, ack_lo, ack_hi;
   logic terminal_count = 1'b0;
   logic counter_irq, even, odd, irq;
   logic [1:0] arm_event = 2'h0, missed_ev = 2'h0, stale_ev = 2'h0;
   logic [1:0] armed, missed, stale;
   int n_errors = 0;
   int comparisons = 0;

   always #2.5 clock = ~clock;

   counter_global_control DUT (.clock(clock), .resetn(resetn),
      .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
      .rdata(rdata), .pin_src(pin_src), .pin_gate(pin_gate),
      .pin_updown(pin_updown), .pin_aux(pin_aux), .ctr_src(ctr_src),
      .ctr_gate(ctr_gate), .ctr_updown(ctr_updown), .ctr_aux(ctr_aux),
      .ctr_out(ctr_out), .pin_out(pin_out), .ctr_dma_req(ctr_dma_req),
      .dma_request_pin(dma_request_pin), .dma_request_oe(dma_request_oe),
      .dma_acknowledge_pin(ack), .ack_low_lane(ack_lo),
      .ack_high_lane(ack_hi), .terminal_count(terminal_count),
      .counter_irq(counter_irq), .arm_event(arm_event),
      .missed_load_event(missed_ev), .stale_event(stale_ev),
      .even_counter_reset_strobe(even), .odd_counter_reset_strobe(odd),
      .counter_armed(armed), .missed_load_flag(missed),
      .sticky_stale_flag(stale), .irq(irq));

   dma_host_model host (.clock(clock), .resetn(resetn),
      .req(dma_request_pin), .req_oe(dma_request_oe), .ack(ack));

   //==================================================================
   // shared tasks
   task automatic results();
      if (n_errors == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clock);
      wr_en <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      @(posedge clock);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clock);
      rd_en <= 1'b0;
      #1 d = rdata;
   endtask

   // counts high cycles of both reset strobes after a pair reset write
   task automatic strobe(input logic [31:0] d, output int n0, n1);
      n0 = 0;
      n1 = 0;
      wr(global_ctl_pkg::OFF_PAIR_RESET, d);
      repeat (4)
      begin
         #1;
         n0 += int'(even === 1'b1);
         n1 += int'(odd === 1'b1);
         @(posedge clock);
      end
   endtask

   task automatic wait_lane(input logic hi);
      for (int i = 0; i < 80 && (hi ? ack_hi[0] : ack_lo[0]) !== 1'b1; i++)
         cyc(1);
   endtask

   //==================================================================
   // scenarios
   task automatic t_after_reset();
      logic [31:0] d;
      logic [11:0] wo [5] = '{12'h190, 12'h192, 12'h73c, 12'h76c, 12'h7fc};
      rd(global_ctl_pkg::OFF_SILICON_ID, d);
      check("id word", 32'h01000000, d);
      check("request oe", 32'h0, {28'h0, dma_request_oe});
      rd(global_ctl_pkg::OFF_STATE, d);
      check("state", 32'h0, d);
      // write-only and unmapped places read back zero
      foreach (wo[i])
      begin
         rd(wo[i], d);
         check("write-only read", 32'h0, d);
      end
   endtask

   task automatic t_swap();
      @(posedge clock);
      pin_src <= 8'h13;
      pin_gate <= 8'h2c;
      pin_updown <= 8'h81;
      pin_aux <= 8'h46;
      ctr_out <= 8'h5a;
      cyc(8);
      check("plain", 32'h132c8146,
         {ctr_src, ctr_gate, ctr_updown, ctr_aux});
      check("plain out", 32'h5a, {24'h0, pin_out});
      wr(global_ctl_pkg::OFF_CLOCK_PIN, 32'h00200000);
      cyc(8);
      check("swap", 32'h31c21864,
         {ctr_src, ctr_gate, ctr_updown, ctr_aux});
      check("swap out", 32'ha5, {24'h0, pin_out});
      wr(global_ctl_pkg::OFF_CLOCK_PIN, 32'h0);
      cyc(8);
      check("unswap", 32'h13, {24'h0, ctr_src});
   endtask

   task automatic t_route();
      logic [31:0] w;
      for (int ch = 0; ch < 4; ch++)
         for (int v = 0; v < 4; v++)
         begin
            w = (32'h1f1f1f1f & ~(32'h1f << (8 * ch))) | (v << (8 * ch));
            wr(global_ctl_pkg::OFF_DMA_ROUTE, w);
            ctr_dma_req <= 4'(1 << v);
            cyc(3);
            check("oe", 32'(1 << ch), {28'h0, dma_request_oe});
            check("req hi", 32'h1, {31'h0, dma_request_pin[ch]});
            @(posedge clock);
            ctr_dma_req <= ~4'(1 << v);
            cyc(3);
            check("req lo", 32'h0, {31'h0, dma_request_pin[ch]});
         end
      // unassigned select codes keep the pin driven, but low
      wr(global_ctl_pkg::OFF_DMA_ROUTE, 32'h1f1f1f05);
      @(posedge clock);
      ctr_dma_req <= 4'hf;
      cyc(3);
      check("unused select", 32'h2,
         {30'h0, dma_request_oe[0], dma_request_pin[0]});
      @(posedge clock);
      ctr_dma_req <= 4'h0;
      wr(global_ctl_pkg::OFF_DMA_ROUTE, 32'h1f1f1f1f);
      cyc(3);
      check("oe off", 32'h0, {28'h0, dma_request_oe});
   endtask

   task automatic t_tc_enable();
      @(posedge clock);
      terminal_count <= 1'b1;
      cyc(3);
      check("tc gated", 32'h0, {31'h0, counter_irq});
      wr(global_ctl_pkg::OFF_IRQ_ENABLE, 32'h40);
      cyc(3);
      check("tc passed", 32'h1, {31'h0, counter_irq});
      wr(global_ctl_pkg::OFF_IRQ_ENABLE, 32'h0);
      cyc(3);
      check("tc gated again", 32'h0, {31'h0, counter_irq});
      @(posedge clock);
      terminal_count <= 1'b0;
   endtask

   task automatic t_pair();
      int n0, n1;
      @(posedge clock);
      arm_event <= 2'b11;
      missed_ev <= 2'b11;
      stale_ev <= 2'b11;
      @(posedge clock);
      arm_event <= 2'b00;
      missed_ev <= 2'b00;
      stale_ev <= 2'b00;
      cyc(3);
      check("flags set", 32'h3f, {26'h0, armed, missed, stale});
      strobe(32'h4, n0, n1);
      check("even strobe", 32'h1, n0);
      check("odd idle", 32'h0, n1);
      check("even reset", 32'h2a,
         {26'h0, armed, missed, stale});
      strobe(32'h8, n0, n1);
      check("odd strobe", 32'h1, n1);
      check("even idle", 32'h0, n0);
      check("odd reset", 32'h0,
         {26'h0, armed, missed, stale});
   endtask

   task automatic t_toggle();
      logic [31:0] d;
      wr(global_ctl_pkg::OFF_DMA_ROUTE, 32'h1f1f1f80);
      ctr_dma_req <= 4'h1;
      wait_lane(1'b0);
      check("first lane", 32'h1, {30'h0, ack_hi[0], ack_lo[0]});
      @(posedge clock);
      ctr_dma_req <= 4'h0;
      cyc(30);
      rd(global_ctl_pkg::OFF_STATE, d);
      check("toggle flipped", 32'h400, d & 32'h400);
      wr(global_ctl_pkg::OFF_DMA_ROUTE, 32'h1f1f1f80);
      rd(global_ctl_pkg::OFF_STATE, d);
      check("toggle cleared", 32'h0, d & 32'h400);
      @(posedge clock);
      ctr_dma_req <= 4'h1;
      wait_lane(1'b0);
      check("low after clear", 32'h1, {30'h0, ack_hi[0], ack_lo[0]});
      wait_lane(1'b1);
      check("next lane high", 32'h2, {30'h0, ack_hi[0], ack_lo[0]});
      @(posedge clock);
      ctr_dma_req <= 4'h0;
      cyc(40);
   endtask

   task automatic t_irq();
      logic [31:0] d;
      cyc(2);
      check("irq masked", 32'h0, {31'h0, irq});
      wr(global_ctl_pkg::OFF_EVT_MASK, 32'h1);
      cyc(3);
      check("irq raised", 32'h1, {31'h0, irq});
      wr(global_ctl_pkg::OFF_EVT_STATUS, 32'h1);
      cyc(3);
      check("irq cleared", 32'h0, {31'h0, irq});
      rd(global_ctl_pkg::OFF_EVT_STATUS, d);
      check("status", 32'he, d);
      wr(global_ctl_pkg::OFF_EVT_STATUS, 32'he);
      rd(global_ctl_pkg::OFF_EVT_STATUS, d);
      check("status clear", 32'h0, d);
   endtask

   //==================================================================
   // main sequence and watchdog
   initial
   begin
      repeat (5) @(posedge clock);
      resetn <= 1'b1;
      t_after_reset();
      t_swap();
      t_route();
      t_tc_enable();
      t_pair();
      t_toggle();
      t_irq();
      results();
   end

   // the sequence needs well under 2000 cycles
   initial
   begin
      #100us;
      n_errors++;
      results();
   end
endmodule
